// file: idf_host.sv
`timescale 1ns/1ps
module idf_host
	import idf_pkg::*;
(
	// clock and returned word
	input wire logic mclk_i,
	input wire logic [15:0] word_data_i,
	// request
	output logic [7:0] word_idx_o,
	output logic word_rd_o
);
	logic shown;
	assign shown = !(word_data_i inside {16'h0000, 16'hffff});
	initial begin
		word_idx_o = 8'h00;
		word_rd_o = 1'b0;
	end
	task rd(input logic [7:0] idx);
		@(posedge mclk_i);
		word_idx_o <= idx;
		word_rd_o <= 1'b1;
		@(posedge mclk_i);
		word_idx_o <= ~idx;
		word_rd_o <= 1'b0;
	endtask : rd
endmodule : idf_host

// file: idf_identify_words.sv
// Operation
// R01: word 68 gives IORDY minimum PIO cycle
// R02: word 53 bit1 set when field supported
// R03: PIO mode 3+ reports fastest mode time
// R04: unsupported field with bit1 set reads zero
// R05: host treats 0000h/FFFFh supported as unreported
// R06: words 83/84 signature bit14 one, 15 zero
// R07: word 82 bits 0,1,5,6 follow support
// R08: word 82 bits 2,4,7-10 are zero
// R09: word 82 bits 3,12,13,14 are one
// R10: word 83 bits 0,1,4 zero, 2 set, 3 APM
// R11: host treats feature words as advisory
// R12: host treats 0000h/FFFFh enabled as unreported
// R13: word 87 signature bit14 one, 15 zero
// R14: word 85 bit0 health enable, retained
// R15: word 85 bits 1,5,6 follow enabled state
// R16: word 85 fixed bits mirror word 82
// R17: word 86 bits 0,1,4 zero, 2 set, 3 APM
// R18: each word read-only, selected by index
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`include "idf_regs.svh"

module idf_identify_words
	import idf_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// retained health enable from nonvolatile store
	input wire logic health_en_nv_i,
	output logic health_en_o,
	// feature events from command logic
	input wire logic security_set_i,
	input wire logic security_clr_i,
	// identify word read port
	input wire logic [7:0] word_idx_i,
	input wire logic word_rd_i,
	output logic [15:0] word_data_o,
	output logic word_valid_o
);
	// =========================================
	// register port decode
	idf_bus_type bus;
	assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

	wire cfg_wr = bus.wr && (bus.addr == `IDF_OFS_CFG);
	wire en_wr = bus.wr && (bus.addr == `IDF_OFS_EN);
	wire cyc_wr = bus.wr && (bus.addr == `IDF_OFS_W68);

	// =========================================
	// capability and enable state
	logic [7:0] cfg_r;
	logic [7:0] en_r;
	logic [15:0] cyc_r;
	logic health_r;
	logic load_r;
	logic security_r;

	// cfg: 0 health,1 security,2 apm,3 wcache,4 lookahead,5 pio3+,6 other 64-70
	idf_feat_type sup;
	idf_feat_type en;
	logic w68_valid;

	assign sup = '{health: cfg_r[0], security: cfg_r[1], wcache: cfg_r[3],
		lookahead: cfg_r[4], apm: cfg_r[2]};
	assign w68_valid = cfg_r[5]; // R03
	// enable bits only stand where the feature exists
	assign en = '{health: health_r & sup.health, security: security_r & sup.security,
		wcache: en_r[3] & sup.wcache, lookahead: en_r[4] & sup.lookahead,
		apm: en_r[2] & sup.apm}; // R15 R17

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cfg_r <= `IDF_CFG_RST;
			en_r <= `IDF_EN_RST;
			cyc_r <= `IDF_CYCLE_NS;
		end else begin
			if (cfg_wr)
				cfg_r <= reg_wdata_i[7:0];
			if (en_wr)
				en_r <= reg_wdata_i[7:0];
			if (cyc_wr)
				cyc_r <= reg_wdata_i; // R01
		end
	end

	// health enable reloads from retained store after reset, not a constant
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			load_r <= 1'b1;
			health_r <= 1'b0;
		end else if (load_r) begin
			load_r <= 1'b0;
			health_r <= health_en_nv_i; // R14
		end else if (en_wr) begin
			health_r <= reg_wdata_i[0]; // R14
		end
	end
	assign health_en_o = health_r;

	// set wins over clear
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			security_r <= 1'b0;
		else if (security_set_i)
			security_r <= 1'b1; // R15
		else if (security_clr_i)
			security_r <= 1'b0;
	end

	// =========================================
	// word selection
	logic [15:0] word_sel;
	logic word_hit;
	logic [15:0] w53_sel;

	idf_word_mux u_mux (
		.idx_i(word_idx_i),
		.sup_i(sup),
		.en_i(en),
		.w68_valid_i(w68_valid),
		.other_6470_i(cfg_r[6]),
		.cyc_ns_i(cyc_r),
		.word_o(word_sel),
		.hit_o(word_hit)
	); // R18

	idf_word_mux u_mux_w53 (
		.idx_i(`IDF_W53),
		.sup_i(sup),
		.en_i(en),
		.w68_valid_i(w68_valid),
		.other_6470_i(cfg_r[6]),
		.cyc_ns_i(cyc_r),
		.word_o(w53_sel),
		.hit_o()
	);

	// =========================================
	// read data registers
	logic [15:0] word_r;
	logic word_v_r;
	logic [15:0] rdata_r;
	logic [15:0] rd_mux;

	assign rd_mux = (bus.addr == `IDF_OFS_CFG) ? {8'h00, cfg_r} :
		(bus.addr == `IDF_OFS_EN) ? {8'h00, 3'b000, en.lookahead, en.wcache,
			en.apm, en.security, en.health} :
		(bus.addr == `IDF_OFS_W53) ? w53_sel :
		(bus.addr == `IDF_OFS_W68) ? cyc_r : 16'h0000;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			word_r <= 16'h0000;
			word_v_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			word_v_r <= word_rd_i;
			if (word_rd_i)
				word_r <= word_hit ? word_sel : 16'h0000; // R18
			rdata_r <= bus.rd ? rd_mux : 16'h0000;
		end
	end

	assign word_data_o = word_r;
	assign word_valid_o = word_v_r;
	assign reg_rdata_o = rdata_r;
endmodule : idf_identify_words

// file: idf_identify_words_props.sv
`timescale 1ns/1ps
module idf_identify_words_props
	import idf_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic [7:0] word_idx_i,
	input wire logic word_rd_i,
	input wire logic [15:0] word_data_o,
	input wire logic word_valid_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	a_valid_pulse: assert property (word_rd_i |=> word_valid_o) else $error("no valid");
	a_word_hold: assert property (!word_rd_i |=> !word_valid_o && $stable(word_data_o))
		else $error("word moved");
	a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000) else $error("rdata");
	a_w82_fixed: assert property (word_rd_i && word_idx_i == 8'h52 |=>
		(word_data_o & 16'h779c) == 16'h7008) else $error("w82");
	a_w85_fixed: assert property (word_rd_i && word_idx_i == 8'h55 |=>
		(word_data_o & 16'h779c) == 16'h7008) else $error("w85");
	a_w83_bits: assert property (word_rd_i && word_idx_i == 8'h53 |=>
		(word_data_o & 16'hfff7) == 16'h4004) else $error("w83");
	a_w86_bits: assert property (word_rd_i && word_idx_i == 8'h56 |=>
		(word_data_o & 16'hfff7) == 16'h0004) else $error("w86");
	a_sig_words: assert property (word_rd_i && word_idx_i inside {8'h54, 8'h57} |=>
		word_data_o == 16'h4000) else $error("sig");
	cover property (word_valid_o && word_data_o[1]);
	cover property (reg_rd_i ##1 reg_rdata_o != 16'h0000);
	cover property (word_rd_i && word_idx_i == 8'h44 ##1 word_data_o != 16'h0000);
endmodule : idf_identify_words_props
bind idf_identify_words idf_identify_words_props u_props (
	.mclk_i(mclk_i),
	.sys_rst_i(sys_rst_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.word_idx_i(word_idx_i),
	.word_rd_i(word_rd_i),
	.word_data_o(word_data_o),
	.word_valid_o(word_valid_o)
);

// file: idf_identify_words_test.sv
`timescale 1ns/1ps
module idf_identify_words_test
	import idf_pkg::*;
;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_d = 1'b0;
	logic security_set_i = 1'b0, security_clr_i = 1'b0, health_en_nv_i = 1'b0, sec = 1'b0;
	logic health_en_o, word_rd_i, word_valid_o;
	logic [7:0] reg_addr_i = 8'h00, word_idx_i;
	logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, word_data_o, cyc = 16'h0050;
	logic [15:0] rq[$], wq[$], we;
	logic [31:0] seed = 32'h1, r;
	logic [6:0] cfg = 7'h6b;
	logic [4:0] en = 5'h00;
	int error_cnt = 0, cmp_count = 0, tick = 0;
	always #10 mclk_i = ~mclk_i;
	idf_identify_words DUT (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.health_en_nv_i(health_en_nv_i),
		.health_en_o(health_en_o),
		.security_set_i(security_set_i),
		.security_clr_i(security_clr_i),
		.word_idx_i(word_idx_i),
		.word_rd_i(word_rd_i),
		.word_data_o(word_data_o),
		.word_valid_o(word_valid_o)
	);
	idf_host u_host (
		.mclk_i(mclk_i),
		.word_data_i(word_data_o),
		.word_idx_o(word_idx_i),
		.word_rd_o(word_rd_i)
	);
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function logic [15:0] ew(input logic [7:0] i);
		logic [4:0] e;
		e = {cfg[4:2] & en[4:2], cfg[1] & sec, cfg[0] & en[0]};
		case (i)
			8'h35: ew = {14'h0, cfg[5] | cfg[6], 1'b0};
			8'h44: ew = cfg[5] ? cyc : 16'h0000;
			8'h52: ew = 16'h7008 | {9'h0, cfg[4:3], 3'h0, cfg[1:0]};
			8'h53: ew = 16'h4004 | {12'h0, cfg[2], 3'h0};
			8'h55: ew = 16'h7008 | {9'h0, e[4:3], 3'h0, e[1:0]};
			8'h56: ew = 16'h0004 | {12'h0, e[2], 3'h0};
			8'h54, 8'h57: ew = 16'h4000;
			default: ew = 16'h0000;
		endcase
	endfunction : ew
	task chk(input logic [15:0] s, e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task rg(input logic w, rd, input logic [7:0] a, input logic [15:0] d, e);
		if (rd)
			rq.push_back(e);
		@(posedge mclk_i);
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, rd, a, d};
		@(posedge mclk_i);
		{reg_wr_i, reg_rd_i} <= 2'b00;
	endtask : rg
	task words;
		for (int k = 0; k < 9; k++) begin
			wq.push_back(ew(k == 8 ? 8'h10 : k < 2 ? 8'h35 + 8'(k * 15) : 8'(80 + k)));
			u_host.rd(k == 8 ? 8'h10 : k < 2 ? 8'h35 + 8'(k * 15) : 8'(80 + k));
		end
	endtask : words
	task stop_test;
		if (rq.size() != 0 || wq.size() != 0)
			error_cnt++;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	always @(posedge mclk_i) begin
		rd_d <= reg_rd_i;
		tick <= tick + 1;
		if (tick == 5000) begin
			error_cnt++;
			stop_test();
		end
	end
	always @(negedge mclk_i) begin
		if (rd_d && rq.size() > 0) chk(reg_rdata_o, rq.pop_front());
		if (word_valid_o === 1'b1 && wq.size() > 0) begin
			we = wq.pop_front();
			chk(word_data_o, we);
			chk({15'h0, u_host.shown}, {15'h0, !(we inside {16'h0000, 16'hffff})});
		end
	end
	initial begin
		repeat (8) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		rg(0, 1, 8'h00, 16'h0, 16'h006b);
		rg(0, 1, 8'h0c, 16'h0, 16'h0050);
		rg(1, 0, 8'h02, 16'hffff, 16'h0);
		rg(0, 1, 8'h02, 16'h0, 16'h0000);
		repeat (20) begin
			r = xs();
			{cyc, sec, en, cfg} = {r[31:16], r[7], r[12:8], r[6:0]};
			rg(1, 0, 8'h00, {9'h0, cfg}, 16'h0);
			rg(1, 0, 8'h04, {11'h0, en}, 16'h0);
			rg(1, 0, 8'h0c, cyc, 16'h0);
			@(posedge mclk_i);
			{security_set_i, security_clr_i} <= {sec, !sec | r[13]};
			@(posedge mclk_i);
			{security_set_i, security_clr_i} <= 2'b00;
			chk({15'h0, health_en_o}, {15'h0, en[0]});
			rg(0, 1, 8'h04, 16'h0, {11'h0, en[4:2] & cfg[4:2], sec & cfg[1], en[0] & cfg[0]});
			rg(0, 1, 8'h08, 16'h0, ew(8'h35));
			words();
		end
		sys_rst_i <= 1'b1;
		health_en_nv_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		{cyc, sec, en, cfg} = {16'h0050, 1'b0, 5'h01, 7'h6b};
		rg(0, 1, 8'h00, 16'h0, 16'h006b);
		rg(0, 1, 8'h04, 16'h0, 16'h0001);
		chk({15'h0, health_en_o}, 16'h0001);
		words();
		repeat (4) @(posedge mclk_i);
		stop_test();
	end
endmodule : idf_identify_words_test

// file: idf_pkg.sv
package idf_pkg;
	typedef struct packed {
		logic health;
		logic security;
		logic wcache;
		logic lookahead;
		logic apm;
	} idf_feat_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} idf_bus_type;
endpackage : idf_pkg

// file: idf_regs.svh
`ifndef IDF_REGS_SVH
`define IDF_REGS_SVH

// identify word indices
`define IDF_W53 8'h35
`define IDF_W68 8'h44
`define IDF_W82 8'h52
`define IDF_W83 8'h53
`define IDF_W84 8'h54
`define IDF_W85 8'h55
`define IDF_W86 8'h56
`define IDF_W87 8'h57

// register port offsets
`define IDF_OFS_CFG 8'h00
`define IDF_OFS_EN 8'h04
`define IDF_OFS_W53 8'h08
`define IDF_OFS_W68 8'h0c

// bit positions
`define IDF_B_HEALTH 0
`define IDF_B_SECURITY 1
`define IDF_B_RMEDIA 2
`define IDF_B_PWRMGMT 3
`define IDF_B_PACKET 4
`define IDF_B_WCACHE 5
`define IDF_B_LOOKAHEAD 6
`define IDF_B_WRBUF 12
`define IDF_B_RDBUF 13
`define IDF_B_NOP 14
`define IDF_B_CARDSET 2
`define IDF_B_APM 3
`define IDF_B_SIG1 14
`define IDF_B_SIG0 15
`define IDF_B_W53_IORDY 1

// fixed patterns and reset values
`define IDF_W82_FIXED 16'h7008
`define IDF_W83_FIXED 16'h4004
`define IDF_SIG_WORD 16'h4000
`define IDF_CYCLE_NS 16'h0050
`define IDF_CFG_RST 8'h6b
`define IDF_EN_RST 8'h00

`endif

// file: idf_word_mux.sv
`timescale 1ns/1ps
`include "idf_regs.svh"

module idf_word_mux
	import idf_pkg::*;
(
	// selection
	input wire logic [7:0] idx_i,
	// feature state
	input wire idf_feat_type sup_i,
	input wire idf_feat_type en_i,
	input wire logic w68_valid_i,
	input wire logic other_6470_i,
	input wire logic [15:0] cyc_ns_i,
	// result
	output logic [15:0] word_o,
	output logic hit_o
);
	// =========================================
	// word assembly
	logic [15:0] w53;
	logic [15:0] w68;
	logic [15:0] w82;
	logic [15:0] w83;
	logic [15:0] w85;
	logic [15:0] w86;

	assign w53 = 16'(w68_valid_i | other_6470_i) << `IDF_B_W53_IORDY; // R02
	assign w68 = w68_valid_i ? cyc_ns_i : 16'h0000; // R01 R03 R04
	assign w82 = `IDF_W82_FIXED // R08 R09
		| (16'(sup_i.health) << `IDF_B_HEALTH) // R07
		| (16'(sup_i.security) << `IDF_B_SECURITY)
		| (16'(sup_i.wcache) << `IDF_B_WCACHE)
		| (16'(sup_i.lookahead) << `IDF_B_LOOKAHEAD);
	assign w83 = `IDF_W83_FIXED | (16'(sup_i.apm) << `IDF_B_APM); // R06 R10
	assign w85 = `IDF_W82_FIXED // R16
		| (16'(en_i.health) << `IDF_B_HEALTH) // R14
		| (16'(en_i.security) << `IDF_B_SECURITY) // R15
		| (16'(en_i.wcache) << `IDF_B_WCACHE)
		| (16'(en_i.lookahead) << `IDF_B_LOOKAHEAD);
	assign w86 = (16'h0001 << `IDF_B_CARDSET) | (16'(en_i.apm) << `IDF_B_APM); // R17

	always_comb begin
		hit_o = 1'b1;
		unique case (idx_i)
			`IDF_W53: word_o = w53;
			`IDF_W68: word_o = w68;
			`IDF_W82: word_o = w82;
			`IDF_W83: word_o = w83;
			`IDF_W84: word_o = `IDF_SIG_WORD; // R06
			`IDF_W85: word_o = w85;
			`IDF_W86: word_o = w86;
			`IDF_W87: word_o = `IDF_SIG_WORD; // R13
			default: begin
				word_o = 16'h0000;
				hit_o = 1'b0;
			end
		endcase
	end
endmodule : idf_word_mux
